/* File: hdl/pfe_cfg.svh */
// register map, field positions, reset values and fetch counts
`ifndef PFE_CFG_SVH
`define PFE_CFG_SVH

`define PFE_CTRL_ADDR 8'hE3
`define PFE_SCALE_ADDR 8'hB0
`define PFE_STAT_ADDR 8'hE4

`define PFE_CTRL_RESET 8'h20
`define PFE_SCALE_RESET 8'h00

`define PFE_CTRL_PFON_BIT 5
`define PFE_CTRL_PAIR_BIT 0
`define PFE_SCALE_FRT_BIT 4

`define PFE_STAT_BUFV_BIT 0
`define PFE_STAT_PFB_BIT 1
`define PFE_STAT_RDB_BIT 2
`define PFE_STAT_PEND_BIT 3

`define PFE_RD_CYC_FAST 1
`define PFE_RD_CYC_SLOW 2

`endif

/* File: hdl/pfe_pkg.sv */
// types and helpers shared by the prefetch engine modules
package pfe_pkg;

  typedef enum logic [1:0] {
    PFE_IDLE = 2'b01,
    PFE_WAIT = 2'b10
  } pfe_dem_t;

  // pick the byte of a fetched code word that the core asked for
  function automatic logic [7:0] pfe_byte_sel(
    input logic [15:0] word,
    input logic hi
  );
    return hi ? word[15:8] : word[7:0];
  endfunction

endpackage

/* File: hdl/pfe_fetch_if.sv */
// fetch start and completion signals between engine and flash reader
interface pfe_fetch_if #(
  parameter int WORD_W = 15
);
  logic start;
  logic slow;
  logic [WORD_W-1:0] word;
  logic done;
  logic busy;

  modport ctl (output start, output slow, output word,
               input done, input busy);
  modport rdr (input start, input slow, input word,
               output done, output busy);
endinterface

/* File: hdl/pfe_flash_rd.sv */
// flash read sequencer: one or two cycles per two-byte code read
`include "pfe_cfg.svh"

module pfe_flash_rd
  import pfe_pkg::*;
#(
  parameter int WORD_W = 15
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fetch control
  pfe_fetch_if.rdr fetch,
  // flash read pins
  output logic o_flash_rd,
  output logic [WORD_W-1:0] o_flash_word
);

  typedef struct packed {
    logic rd;
    logic left;
    logic [WORD_W-1:0] word;
  } pfe_rd_state_t;

  localparam pfe_rd_state_t RD_RESET = '0;

  pfe_rd_state_t state_reg;
  pfe_rd_state_t state_next;

  // a new start aborts a read in flight; the engine only does that
  // when the old data is no longer wanted
  always_comb
  begin
    state_next = state_reg;
    if (fetch.start)
    begin
      state_next.rd = 1'b1;
      state_next.word = fetch.word;
      state_next.left = fetch.slow ? 1'(`PFE_RD_CYC_SLOW - 1)
                                   : 1'(`PFE_RD_CYC_FAST - 1); // [RULE_05]
    end
    else if (state_reg.rd && state_reg.left)
      state_next.left = 1'b0;
    else
      state_next.rd = 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_reg <= RD_RESET;
    else
      state_reg <= state_next;
  end

  assign fetch.done = state_reg.rd && !state_reg.left; // [RULE_06] [RULE_07]
  assign fetch.busy = state_reg.rd;
  assign o_flash_rd = state_reg.rd;
  assign o_flash_word = state_reg.word;

endmodule // pfe_flash_rd

/* File: hdl/pfe_wrpair.sv */
// software flash write path: single bytes or byte pairs
`include "pfe_cfg.svh"

module pfe_wrpair
  import pfe_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // mode
  input wire logic i_pair_on,
  // byte writes from software
  input wire logic i_req,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_data,
  // flash write pins
  output logic o_wr,
  output logic [ADDR_W-2:0] o_word,
  output logic [15:0] o_data,
  output logic [1:0] o_mask,
  output logic o_pend
);

  typedef struct packed {
    logic pend;
    logic [ADDR_W-2:0] pend_word;
    logic [7:0] pend_byte;
    logic wr;
    logic [ADDR_W-2:0] word;
    logic [15:0] data;
    logic [1:0] mask;
  } pfe_wr_state_t;

  localparam pfe_wr_state_t WR_RESET = '0;

  pfe_wr_state_t state_reg;
  pfe_wr_state_t state_next;

  always_comb
  begin
    state_next = state_reg;
    state_next.wr = 1'b0;
    if (!i_pair_on)
      state_next.pend = 1'b0;
    if (i_req)
    begin
      state_next.word = i_addr[ADDR_W-1:1];
      state_next.data = {i_data, i_data};
      state_next.mask = i_addr[0] ? 2'b10 : 2'b01;
      if (!i_pair_on)
        state_next.wr = 1'b1; // [RULE_10]
      else if (!i_addr[0])
      begin
        // even byte waits for its partner; a newer even byte replaces it
        state_next.pend = 1'b1;
        state_next.pend_word = i_addr[ADDR_W-1:1];
        state_next.pend_byte = i_data;
      end
      else if (state_reg.pend && state_reg.pend_word == i_addr[ADDR_W-1:1])
      begin
        state_next.wr = 1'b1;
        state_next.data = {i_data, state_reg.pend_byte};
        state_next.mask = 2'b11; // [RULE_10]
        state_next.pend = 1'b0;
      end
      else
        state_next.wr = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_reg <= WR_RESET;
    else
      state_reg <= state_next;
  end

  assign o_wr = state_reg.wr;
  assign o_word = state_reg.word;
  assign o_data = state_reg.data;
  assign o_mask = state_reg.mask;
  assign o_pend = state_reg.pend;

endmodule // pfe_wrpair

/* File: hdl/pfe_top.sv */
// instruction prefetch engine between program flash and the core
//
// Contract
// RULE_01: a two-byte prefetch buffer sits between flash and core.
// RULE_02: every flash read returns two consecutive code bytes for the core.
// RULE_03: straight-line code is served with no core wait states; the core stalls after an odd entry and on a high byte whose word was evicted.
// RULE_04: after a branch the core stalls at most two cycles.
// RULE_05: read-timing bit 4 of the scale register sets fetch length.
// RULE_06: read-timing zero gives one-cycle fetches, for clocks to 25 MHz.
// RULE_07: read-timing one gives two-cycle fetches, above 25 MHz to 50 MHz.
// RULE_08: software enables prefetch whenever the clock exceeds 25 MHz.
// RULE_09: control bit 5 enables the prefetch engine when set.
// RULE_10: control bit 0 selects single-byte or paired flash writes.
// RULE_11: control bits 7..6 and 4..1 read zero, writes ignored.
// RULE_12: software disables prefetch before changing read timing.
// RULE_13: branch or disable drops buffered bytes; fetch freshly from flash.
//
// The address-and-strobe port is this design's own decision.
`include "pfe_cfg.svh"

module pfe_top
  import pfe_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // core instruction fetch
  input wire logic i_core_req,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic i_core_branch,
  output logic o_core_valid,
  output logic [7:0] o_core_data,
  // flash code read
  output logic o_flash_rd,
  output logic [ADDR_W-2:0] o_flash_word,
  input wire logic [15:0] i_flash_data,
  // software flash writes
  input wire logic i_fw_req,
  input wire logic [ADDR_W-1:0] i_fw_addr,
  input wire logic [7:0] i_fw_data,
  output logic o_fw_wr,
  output logic [ADDR_W-2:0] o_fw_word,
  output logic [15:0] o_fw_data,
  output logic [1:0] o_fw_mask
);

  localparam int WORD_W = ADDR_W - 1;

  if (ADDR_W < 2 || ADDR_W > 32)
  begin : g_check
    $error("pfe_top: ADDR_W must lie between 2 and 32");
  end

  // the reader keeps a single extra-cycle flag, so reads last one or two
  if (`PFE_RD_CYC_FAST < 1 || `PFE_RD_CYC_FAST > 2
      || `PFE_RD_CYC_SLOW < 1 || `PFE_RD_CYC_SLOW > 2)
  begin : g_check_cyc
    $error("pfe_top: flash read cycle counts must be 1 or 2");
  end

  // the read mux decodes one register per address
  if (`PFE_CTRL_ADDR == `PFE_SCALE_ADDR
      || `PFE_CTRL_ADDR == `PFE_STAT_ADDR
      || `PFE_SCALE_ADDR == `PFE_STAT_ADDR)
  begin : g_check_map
    $error("pfe_top: register addresses must differ");
  end

  // every field must fall inside the 8-bit registers
  if (`PFE_CTRL_PFON_BIT > 7 || `PFE_CTRL_PAIR_BIT > 7
      || `PFE_SCALE_FRT_BIT > 7 || `PFE_STAT_BUFV_BIT > 7
      || `PFE_STAT_PFB_BIT > 7 || `PFE_STAT_RDB_BIT > 7
      || `PFE_STAT_PEND_BIT > 7)
  begin : g_check_bits
    $error("pfe_top: register fields must lie in bits 7 to 0");
  end

  typedef struct packed {
    logic pf_on;
    logic pair_on;
    logic frt;
    pfe_dem_t dem;
    logic [ADDR_W-1:0] dem_addr;
    logic buf_valid;
    logic [WORD_W-1:0] buf_word;
    logic [15:0] buf_data;
    logic pf_busy;
    logic [WORD_W-1:0] pf_word;
    logic core_valid;
    logic [7:0] core_data;
    logic [7:0] rdata;
  } pfe_state_t;

  // reset images of the registers, picked apart field by field
  localparam logic [7:0] CTRL_RST = `PFE_CTRL_RESET;
  localparam logic [7:0] SCALE_RST = `PFE_SCALE_RESET;

  localparam pfe_state_t TOP_RESET = '{
    pf_on: CTRL_RST[`PFE_CTRL_PFON_BIT],
    pair_on: CTRL_RST[`PFE_CTRL_PAIR_BIT],
    frt: SCALE_RST[`PFE_SCALE_FRT_BIT],
    dem: PFE_IDLE,
    default: '0
  };

  pfe_state_t state_reg;
  pfe_state_t state_next;

  pfe_fetch_if #(.WORD_W(WORD_W)) fetch ();

  logic wr_pend;
  logic [WORD_W-1:0] req_word;
  logic [WORD_W-1:0] seq_word;
  logic hit_buf;
  logic hit_pf;
  logic pf_landing;

  // word following the one the core is reading; wraps at the top
  function automatic logic [WORD_W-1:0] next_word(
    input logic [WORD_W-1:0] w
  );
    return w + WORD_W'(1);
  endfunction

  // software views of the registers; unused bits always read zero
  function automatic logic [7:0] ctrl_view(
    input logic pf_on,
    input logic pair_on
  );
    logic [7:0] v;
    v = 8'h00;
    v[`PFE_CTRL_PFON_BIT] = pf_on;
    v[`PFE_CTRL_PAIR_BIT] = pair_on;
    return v;
  endfunction

  function automatic logic [7:0] scale_view(
    input logic frt
  );
    logic [7:0] v;
    v = 8'h00;
    v[`PFE_SCALE_FRT_BIT] = frt;
    return v;
  endfunction

  // status is read only; it exposes engine state for software polling
  function automatic logic [7:0] stat_view(
    input logic buf_valid,
    input logic pf_busy,
    input logic rd_busy,
    input logic pend
  );
    logic [7:0] v;
    v = 8'h00;
    v[`PFE_STAT_BUFV_BIT] = buf_valid;
    v[`PFE_STAT_PFB_BIT] = pf_busy;
    v[`PFE_STAT_RDB_BIT] = rd_busy;
    v[`PFE_STAT_PEND_BIT] = pend;
    return v;
  endfunction

  pfe_flash_rd #(
    .WORD_W(WORD_W)
  ) u_rd (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .fetch(fetch.rdr),
    .o_flash_rd(o_flash_rd),
    .o_flash_word(o_flash_word)
  );

  pfe_wrpair #(
    .ADDR_W(ADDR_W)
  ) u_wr (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pair_on(state_reg.pair_on),
    .i_req(i_fw_req),
    .i_addr(i_fw_addr),
    .i_data(i_fw_data),
    .o_wr(o_fw_wr),
    .o_word(o_fw_word),
    .o_data(o_fw_data),
    .o_mask(o_fw_mask),
    .o_pend(wr_pend)
  );

  assign req_word = i_core_addr[ADDR_W-1:1];
  assign seq_word = next_word(req_word);
  assign pf_landing = state_reg.pf_busy && fetch.done;

  // a branch never trusts the buffer, even if the target word matches
  assign hit_buf = state_reg.pf_on && !i_core_branch
                   && state_reg.buf_valid
                   && state_reg.buf_word == req_word; // [RULE_13]

  // bypass: a prefetch finishing this cycle answers without a wait
  assign hit_pf = state_reg.pf_on && !i_core_branch && pf_landing
                  && state_reg.pf_word == req_word; // [RULE_03]

  always_comb
  begin
    state_next = state_reg;
    state_next.core_valid = 1'b0;
    state_next.rdata = 8'h00;
    fetch.start = 1'b0;
    fetch.slow = state_reg.frt; // [RULE_05]
    fetch.word = req_word;

    // register writes; unused control bits are simply not stored
    if (i_reg_wr)
    begin
      if (i_reg_addr == `PFE_CTRL_ADDR)
      begin
        state_next.pf_on = i_reg_wdata[`PFE_CTRL_PFON_BIT]; // [RULE_09]
        state_next.pair_on = i_reg_wdata[`PFE_CTRL_PAIR_BIT]; // [RULE_10]
      end
      if (i_reg_addr == `PFE_SCALE_ADDR)
        state_next.frt = i_reg_wdata[`PFE_SCALE_FRT_BIT]; // [RULE_05]
    end

    // register reads; unmapped addresses and unused bits read zero
    if (i_reg_rd)
    begin
      case (i_reg_addr)
        `PFE_CTRL_ADDR:
          state_next.rdata = ctrl_view(state_reg.pf_on,
                                       state_reg.pair_on); // [RULE_11]
        `PFE_SCALE_ADDR:
          state_next.rdata = scale_view(state_reg.frt); // [RULE_11]
        `PFE_STAT_ADDR:
          state_next.rdata = stat_view(state_reg.buf_valid,
                                       state_reg.pf_busy,
                                       fetch.busy,
                                       wr_pend);
        default:
          state_next.rdata = 8'h00;
      endcase
    end

    // disabled engine keeps nothing
    if (!state_reg.pf_on)
    begin
      state_next.buf_valid = 1'b0; // [RULE_13]
      state_next.pf_busy = 1'b0;
    end

    // a finished prefetch replaces the whole two-byte buffer
    if (pf_landing)
    begin
      state_next.buf_valid = 1'b1;
      state_next.buf_word = state_reg.pf_word;
      state_next.buf_data = i_flash_data; // [RULE_01] [RULE_02]
      state_next.pf_busy = 1'b0;
    end

    // demand side: a miss parks here until the reader hands the word over
    unique case (state_reg.dem)
      PFE_WAIT:
      begin
        if (fetch.done)
        begin
          state_next.core_valid = 1'b1;
          state_next.core_data = pfe_byte_sel(i_flash_data, // [RULE_02]
                                              state_reg.dem_addr[0]);
          state_next.dem = PFE_IDLE;
          if (state_reg.pf_on)
          begin
            state_next.buf_valid = 1'b1;
            state_next.buf_word = state_reg.dem_addr[ADDR_W-1:1];
            state_next.buf_data = i_flash_data; // [RULE_01]
            // low byte served: the high byte is already held, so
            // start on the following word straight away
            if (!state_reg.dem_addr[0])
            begin
              fetch.start = 1'b1;
              fetch.word = next_word(state_reg.dem_addr[ADDR_W-1:1]);
              state_next.pf_busy = 1'b1;
              state_next.pf_word = fetch.word; // [RULE_03]
            end
          end
        end
      end
      PFE_IDLE:
      begin
        if (i_core_req)
        begin
          if (hit_buf || hit_pf)
          begin
            state_next.core_valid = 1'b1;
            state_next.core_data = pfe_byte_sel(
              hit_buf ? state_reg.buf_data : i_flash_data,
              i_core_addr[0]); // [RULE_03]
            // low byte taken: fetch ahead unless a read is still owed
            if (!i_core_addr[0] && (!state_reg.pf_busy || pf_landing))
            begin
              fetch.start = 1'b1;
              fetch.word = seq_word;
              state_next.pf_busy = 1'b1;
              state_next.pf_word = seq_word; // [RULE_03]
            end
          end
          else
          begin
            // miss: abort any prefetch and read the target itself;
            // two-cycle reads leave the core two cycles short
            if (i_core_branch || !state_reg.pf_on)
              state_next.buf_valid = 1'b0; // [RULE_13]
            state_next.pf_busy = 1'b0;
            fetch.start = 1'b1;
            fetch.word = req_word; // [RULE_04] [RULE_13]
            state_next.dem = PFE_WAIT;
            state_next.dem_addr = i_core_addr;
          end
        end
      end
      default:
        state_next.dem = PFE_IDLE;
    endcase
  end

  // read timing is captured at each read start, so a change under an
  // enabled engine cannot tear a read; software still disables first
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      state_reg <= TOP_RESET;
    else
      state_reg <= state_next;
  end

  assign o_reg_rdata = state_reg.rdata;
  assign o_core_valid = state_reg.core_valid;
  assign o_core_data = state_reg.core_data;

endmodule // pfe_top

/* File: test/pfe_flash_model.sv */
// program flash model: two code bytes per word address
module pfe_flash_model #(
  parameter int WORD_W = 15
)
(
  // clock
  input wire logic i_clk,
  // read port
  input wire logic i_rd,
  input wire logic [WORD_W-1:0] i_word,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_reg = 1'b0;
  always_ff @(posedge i_clk)
  begin
    flip_reg <= ~flip_reg;
  end
  // outside a read the lines change every cycle, so stale data never match
  assign o_data = i_rd ? {i_word[7:0] ^ 8'hA5, i_word[7:0]}
                       : {16{flip_reg}} ^ 16'h5A5A;
endmodule // pfe_flash_model

/* File: test/pfe_top_sva.sv */
// checker on the prefetch engine top ports
module pfe_top_sva #(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // core fetch and flash read
  input wire logic i_core_req,
  input wire logic [ADDR_W-1:0] i_core_addr,
  input wire logic i_core_branch,
  input wire logic o_core_valid,
  input wire logic o_flash_rd,
  input wire logic [ADDR_W-2:0] o_flash_word,
  // flash writes
  input wire logic i_fw_req,
  input wire logic [ADDR_W-1:0] i_fw_addr,
  input wire logic [7:0] i_fw_data,
  input wire logic o_fw_wr,
  input wire logic [15:0] o_fw_data,
  input wire logic [1:0] o_fw_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pf_reg;
  logic slow_reg;
  logic pair_reg;
  // mirror of the settings, so latencies can be tied to them
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pf_reg <= 1'b1;
      slow_reg <= 1'b0;
      pair_reg <= 1'b0;
    end
    else if (i_reg_wr && i_reg_addr == 8'hE3)
    begin
      pf_reg <= i_reg_wdata[5];
      pair_reg <= i_reg_wdata[0];
    end
    else if (i_reg_wr && i_reg_addr == 8'hB0)
    begin
      slow_reg <= i_reg_wdata[4];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  rdata_idle_a: assert property (
    !i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data not zero");
  ctrl_read_a: assert property (i_reg_rd && i_reg_addr == 8'hE3
    |=> o_reg_rdata == {2'b00, pf_reg, 4'h0, pair_reg})
    else $error("control readback wrong");
  scale_read_a: assert property (i_reg_rd && i_reg_addr == 8'hB0
    |=> o_reg_rdata == {3'b000, slow_reg, 4'h0})
    else $error("scale readback wrong");
  branch_stall_a: assert property (i_core_req && i_core_branch
    |-> ##[1:3] o_core_valid) else $error("branch stall too long");
  branch_fetch_a: assert property (i_core_req && i_core_branch
    |=> o_flash_rd && o_flash_word == $past(i_core_addr[ADDR_W-1:1]))
    else $error("branch did not read flash");
  miss_fast_a: assert property (i_core_req && !pf_reg && !slow_reg
    |=> o_flash_rd ##1 !o_flash_rd && o_core_valid)
    else $error("fast miss timing wrong");
  miss_slow_a: assert property (i_core_req && !pf_reg && slow_reg
    |=> o_flash_rd [*2] ##1 !o_flash_rd && o_core_valid)
    else $error("slow miss timing wrong");
  no_prefetch_a: assert property (!pf_reg && $rose(o_flash_rd)
    |-> $past(i_core_req)) else $error("prefetch while disabled");
  fw_single_a: assert property (i_fw_req && !pair_reg |=> o_fw_wr
    && o_fw_mask == {$past(i_fw_addr[0]), !$past(i_fw_addr[0])}
    && o_fw_data == {2{$past(i_fw_data)}}) else $error("single write wrong");
  fw_hold_a: assert property (
    i_fw_req && pair_reg && !i_fw_addr[0] |=> !o_fw_wr)
    else $error("even byte not held");
  cover property (i_core_req && i_core_branch ##3 o_core_valid);
  cover property (o_fw_wr && o_fw_mask == 2'b11);
  cover property (i_core_req && !pf_reg && slow_reg);
endmodule // pfe_top_sva

bind pfe_top pfe_top_sva #(.ADDR_W(ADDR_W)) u_pfe_top_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_core_req(i_core_req),
  .i_core_addr(i_core_addr), .i_core_branch(i_core_branch),
  .o_core_valid(o_core_valid), .o_flash_rd(o_flash_rd),
  .o_flash_word(o_flash_word), .i_fw_req(i_fw_req),
  .i_fw_addr(i_fw_addr), .i_fw_data(i_fw_data), .o_fw_wr(o_fw_wr),
  .o_fw_data(o_fw_data), .o_fw_mask(o_fw_mask)
);

/* File: test/tb_top.sv */
// self-checking testbench for the prefetch engine
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic core_req = 1'b0;
  logic [15:0] core_addr = 16'h0000;
  logic core_branch = 1'b0;
  logic fw_req = 1'b0;
  logic [15:0] fw_addr = 16'h0000;
  logic [7:0] fw_data = 8'h00;
  logic [7:0] o_reg_rdata;
  logic o_core_valid;
  logic [7:0] o_core_data;
  logic o_flash_rd;
  logic [14:0] o_flash_word;
  logic [15:0] flash_data;
  logic o_fw_wr;
  logic [14:0] o_fw_word;
  logic [15:0] o_fw_data;
  logic [1:0] o_fw_mask;
  int n_mismatch = 0;
  int tests_run = 0;

  always #12.5 i_clk = ~i_clk;

  pfe_top u_pfe_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_core_req(core_req),
    .i_core_addr(core_addr), .i_core_branch(core_branch),
    .o_core_valid(o_core_valid), .o_core_data(o_core_data),
    .o_flash_rd(o_flash_rd), .o_flash_word(o_flash_word),
    .i_flash_data(flash_data), .i_fw_req(fw_req), .i_fw_addr(fw_addr),
    .i_fw_data(fw_data), .o_fw_wr(o_fw_wr), .o_fw_word(o_fw_word),
    .o_fw_data(o_fw_data), .o_fw_mask(o_fw_mask)
  );
  pfe_flash_model u_pfe_flash_model (
    .i_clk(i_clk), .i_rd(o_flash_rd), .i_word(o_flash_word),
    .o_data(flash_data)
  );

  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  // code byte the flash model holds at a byte address
  function automatic logic [15:0] fb(input logic [15:0] a);
    return {8'h00, a[0] ? a[8:1] ^ 8'hA5 : a[8:1]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, o_reg_rdata}, {8'h00, exp});
  endtask

  // first byte after lat cycles, then one request in every answer cycle but the last
  task automatic stream(input logic [15:0] a, input int n, input int lat,
                        input logic br);
    logic [15:0] x;
    x = a;
    @(posedge i_clk);
    core_req <= 1'b1;
    core_addr <= x;
    core_branch <= br;
    @(posedge i_clk);
    core_req <= 1'b0;
    core_branch <= 1'b0;
    repeat (lat - 1) @(posedge i_clk);
    for (int i = 0; i < n; i++)
    begin
      core_req <= (i < n - 1);
      core_addr <= x + 16'h0001;
      #1;
      check({15'h0000, o_core_valid}, 16'h0001);
      check({8'h00, o_core_data}, fb(x));
      x = x + 16'h0001;
      @(posedge i_clk);
    end
  endtask

  task automatic t_regs;
    rd(8'hE3, 8'h20);
    rd(8'hB0, 8'h00);
    wr(8'hE3, 8'hFE);
    rd(8'hE3, 8'h20);
    wr(8'hE3, 8'hDF);
    rd(8'hE3, 8'h01);
    wr(8'hB0, 8'hFF);
    rd(8'hB0, 8'h10);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
  endtask

  task automatic t_fetch;
    int n;
    for (int s = 0; s < 2; s++)
    begin
      n = s + 1;
      wr(8'hE3, 8'h00);
      wr(8'hB0, (s == 1) ? 8'h10 : 8'h00);
      wr(8'hE3, 8'h20);
      stream(16'h0100, 6, n + 1, 1'b1);
      stream(16'h0231, 1, n + 1, 1'b1);
      stream(16'h0300, 1, n + 1, 1'b1);
      stream(16'h0301, 1, n + 1, 1'b1);
      rd(8'hE4, 8'h01);
      wr(8'hE3, 8'h00);
      stream(16'h0400, 1, n + 1, 1'b0);
      stream(16'h0401, 1, n + 1, 1'b0);
      rd(8'hE4, 8'h00);
    end
  endtask

  task automatic fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    fw_req <= 1'b1;
    fw_addr <= a;
    fw_data <= d;
    @(posedge i_clk);
    fw_req <= 1'b0;
    #1;
  endtask

  task automatic t_fw;
    wr(8'hE3, 8'h20);
    fw(16'h0500, 8'h3C);
    check({7'h00, o_fw_wr, 6'h00, o_fw_mask}, 16'h0101);
    check(o_fw_data, 16'h3C3C);
    fw(16'h0501, 8'h5A);
    check({7'h00, o_fw_wr, 6'h00, o_fw_mask}, 16'h0102);
    check({1'b0, o_fw_word}, 16'h0280);
    wr(8'hE3, 8'h21);
    @(posedge i_clk);
    fw_req <= 1'b1;
    fw_addr <= 16'h0600;
    fw_data <= 8'h11;
    @(posedge i_clk);
    fw_addr <= 16'h0601;
    fw_data <= 8'h22;
    #1;
    check({15'h0000, o_fw_wr}, 16'h0000);
    @(posedge i_clk);
    fw_req <= 1'b0;
    #1;
    check({7'h00, o_fw_wr, 6'h00, o_fw_mask}, 16'h0103);
    check(o_fw_data, 16'h2211);
    fw(16'h0701, 8'h33);
    check({7'h00, o_fw_wr, 6'h00, o_fw_mask}, 16'h0102);
    fw(16'h0800, 8'h44);
    check({15'h0000, o_fw_wr}, 16'h0000);
    rd(8'hE4, 8'h08);
    wr(8'hE3, 8'h20);
    rd(8'hE4, 8'h00);
  endtask

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    report_and_stop;
  end

  initial
  begin
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs;
    t_fetch;
    t_fw;
    report_and_stop;
  end
endmodule // tb_top
